// >>> hdl/dtc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"

module dtc_top
  import dtc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_irq_pin0,
  input wire logic i_ext_irq_pin1,
  input wire logic i_timer0_count_pin,
  input wire logic i_timer1_count_pin,
  output logic [7:0] o_rdata,
  output logic o_irq
);

  logic [7:0] timer_mode_config;
  logic [7:0] timer_prescale_select;
  logic [1:0] run_ctrl;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;

  logic [1:0] irq_meta;
  logic [1:0] irq_sync;
  logic [1:0] cnt_meta;
  logic [1:0] cnt_sync;

  logic [7:0] low_q [2];
  logic [7:0] high_q [2];
  logic [1:0] ovf_pulse;
  logic split_ovf_pulse;

  logic wr_run;
  logic wr_mode;
  logic wr_prescale;
  logic wr_mask;
  logic wr_status;
  logic irq_pend;
  logic [7:0] next_rdata;

  // one decode per register keeps the write blocks short
  assign wr_run = i_wr && (i_addr == `DTC_RUN_ADDR);
  assign wr_mode = i_wr && (i_addr == `DTC_MODE_CFG_ADDR);
  assign wr_prescale = i_wr && (i_addr == `DTC_PRESCALE_ADDR);
  assign wr_mask = i_wr && (i_addr == `DTC_IRQ_MASK_ADDR);
  assign wr_status = i_wr && (i_addr == `DTC_IRQ_STAT_ADDR);

  // two-flop synchronisers; only the second stage is read by logic
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_meta <= 2'h0;
      irq_sync <= 2'h0;
    end else begin
      irq_meta <= {i_ext_irq_pin1, i_ext_irq_pin0};
      irq_sync <= irq_meta;
    end
  end

  // count pins reset low, so a pin idling high only looks like a rising edge
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_meta <= 2'h0;
      cnt_sync <= 2'h0;
    end else begin
      cnt_meta <= {i_timer1_count_pin, i_timer0_count_pin};
      cnt_sync <= cnt_meta;
    end
  end

  // configuration registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_mode_config <= `DTC_MODE_CFG_RST; // [RULE_19]
    end else if (wr_mode) begin
      timer_mode_config <= i_wdata;
    end
  end

  // reserved bits are never stored, so they read back as zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_prescale_select <= `DTC_PRESCALE_RST; // [RULE_03]
    end else if (wr_prescale) begin
      timer_prescale_select <= i_wdata & `DTC_PRESCALE_MASK; // [RULE_03]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_ctrl <= 2'h0;
    end else if (wr_run) begin
      run_ctrl <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask <= 3'h0;
    end else if (wr_mask) begin
      irq_mask <= i_wdata[2:0];
    end
  end

  // write-one-to-clear; a new overflow in the same cycle wins over the clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set = {split_ovf_pulse, ovf_pulse};
  assign irq_clr = wr_status ? i_wdata[2:0] : 3'h0;
  assign irq_pend = |(irq_status & irq_mask);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set; // [RULE_18]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_pend;
    end
  end

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_tmr
    localparam int MB = gi * `DTC_MODE_STRIDE;
    localparam logic [7:0] LOW_ADDR = (gi == 0) ? `DTC_T0_LOW_ADDR : `DTC_T1_LOW_ADDR;
    localparam logic [7:0] HIGH_ADDR = (gi == 0) ? `DTC_T0_HIGH_ADDR : `DTC_T1_HIGH_ADDR;

    dtc_mode_e mode;
    logic src_pin;
    logic gate;
    logic fast;
    logic [3:0] div_last;
    logic [3:0] pcnt;
    logic tick;
    logic enable;
    logic prev_pin;
    logic edge_pend;
    logic count_evt;
    logic split_high_evt;
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
    logic split_ovf;
    logic wr_low;
    logic wr_high;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic next_ovf;
    logic next_split_ovf;

    assign mode = dtc_mode_e'(timer_mode_config[MB+1:MB]);
    assign src_pin = timer_mode_config[MB+`DTC_SRC_OFS];
    assign gate = timer_mode_config[MB+`DTC_GATE_OFS];
    assign fast = timer_prescale_select[`DTC_FAST_BIT_BASE+gi];

    // machine cycle of 12 or 4 system clocks
    assign div_last = (fast ? `DTC_DIV_FAST : `DTC_DIV_SLOW) - 4'h1; // [RULE_01] [RULE_02]
    assign tick = (pcnt >= div_last);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        pcnt <= 4'h0;
      end else if (tick) begin
        pcnt <= 4'h0;
      end else begin
        pcnt <= pcnt + 4'h1;
      end
    end

    // the pin is looked at once per machine cycle
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        prev_pin <= 1'b0;
      end else if (tick) begin
        prev_pin <= cnt_sync[gi]; // [RULE_16]
      end
    end

    // a falling edge seen at one tick is counted at the next tick
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        edge_pend <= 1'b0;
      end else if (tick) begin
        edge_pend <= prev_pin & ~cnt_sync[gi]; // [RULE_16]
      end
    end

    assign enable = run_ctrl[gi] & (~gate | irq_sync[gi]); // [RULE_04] [RULE_05] [RULE_10] [RULE_15]
    assign count_evt = tick & enable & (src_pin ? edge_pend : 1'b1); // [RULE_06] [RULE_11]
    // in split mode the high byte of timer 0 borrows timer 1's run bit
    assign split_high_evt = (gi == 0) && (mode == DTC_MODE_SPLIT) && tick && run_ctrl[1]; // [RULE_14]

    assign wr_low = i_wr && (i_addr == LOW_ADDR);
    assign wr_high = i_wr && (i_addr == HIGH_ADDR);

    // software writes land after counting, so a write always sticks
    always_comb begin
      next_low = low;
      next_high = high;
      next_ovf = 1'b0;
      next_split_ovf = 1'b0;
      if (count_evt) begin
        unique case (mode)
          DTC_MODE_13BIT: begin
            next_low[4:0] = low[4:0] + 5'h01; // [RULE_07] [RULE_12] [RULE_17]
            if (low[4:0] == 5'h1f) begin
              next_high = high + 8'h01; // [RULE_17]
              next_ovf = (high == 8'hff);
            end
          end
          DTC_MODE_16BIT: begin
            {next_high, next_low} = {high, low} + 16'h0001; // [RULE_07] [RULE_12]
            next_ovf = ({high, low} == 16'hffff); // [RULE_18]
          end
          DTC_MODE_RELOAD: begin
            if (low == 8'hff) begin
              next_low = high; // [RULE_08] [RULE_13]
              next_ovf = 1'b1;
            end else begin
              next_low = low + 8'h01;
            end
          end
          DTC_MODE_SPLIT: begin
            // timer 1 simply holds its count here
            if (gi == 0) begin
              next_low = low + 8'h01; // [RULE_14]
              next_ovf = (low == 8'hff);
            end
          end // [RULE_09]
        endcase
      end
      if (split_high_evt) begin
        next_high = high + 8'h01; // [RULE_14]
        next_split_ovf = (high == 8'hff);
      end
      if (wr_low) begin
        next_low = i_wdata;
      end
      if (wr_high) begin
        next_high = i_wdata;
      end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        low <= 8'h00;
        high <= 8'h00;
      end else begin
        low <= next_low;
        high <= next_high;
      end
    end

    // overflow pulses last one cycle; the sticky copy lives in the status register
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ovf <= 1'b0;
        split_ovf <= 1'b0;
      end else begin
        ovf <= next_ovf;
        split_ovf <= next_split_ovf;
      end
    end

    assign low_q[gi] = low;
    assign high_q[gi] = high;
    assign ovf_pulse[gi] = ovf;
  end

  assign split_ovf_pulse = g_tmr[0].split_ovf;

  // read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (i_addr)
      `DTC_RUN_ADDR: begin
        next_rdata = {6'h00, run_ctrl};
      end
      `DTC_MODE_CFG_ADDR: begin
        next_rdata = timer_mode_config;
      end
      `DTC_T0_LOW_ADDR: begin
        next_rdata = low_q[0];
      end
      `DTC_T1_LOW_ADDR: begin
        next_rdata = low_q[1];
      end
      `DTC_T0_HIGH_ADDR: begin
        next_rdata = high_q[0];
      end
      `DTC_T1_HIGH_ADDR: begin
        next_rdata = high_q[1];
      end
      `DTC_PRESCALE_ADDR: begin
        next_rdata = timer_prescale_select;
      end
      `DTC_IRQ_STAT_ADDR: begin
        next_rdata = {5'h00, irq_status};
      end
      `DTC_IRQ_MASK_ADDR: begin
        next_rdata = {5'h00, irq_mask};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/dtc_defs.svh
// How it works
// RULE_01 - timer 1 prescale bit 0 divides system clock by 12, 1 by 4
// RULE_02 - timer 0 prescale bit 0 divides system clock by 12, 1 by 4
// RULE_03 - prescale register resets to zero; bits 7:5 and 2:0 reserved
// RULE_04 - timer 1 gate bit clear: count whenever run is set, pin ignored
// RULE_05 - timer 1 gate bit set: count only while run set and irq pin 1 high
// RULE_06 - timer 1 source bit: 0 internal ticks, 1 falling edges of count pin
// RULE_07 - timer 1 mode 00 is 13-bit with 5-bit low prescaler, 01 is 16-bit
// RULE_08 - timer 1 mode 10 is 8-bit low byte reloaded from high byte
// RULE_09 - timer 1 mode 11 halts timer 1
// RULE_10 - timer 0 gate bit clear: count whenever run is set, pin ignored
// RULE_11 - timer 0 source bit: 0 internal ticks, 1 falling edges of count pin
// RULE_12 - timer 0 mode 00 is 13-bit with 5-bit low prescaler, 01 is 16-bit
// RULE_13 - timer 0 mode 10 is 8-bit low byte reloaded from high byte
// RULE_14 - timer 0 mode 11 splits into two independent 8-bit timers
// RULE_15 - counting enabled only if run set and gate clear or irq pin high; the split-mode high byte of timer 0 counts on timer 1 run bit alone
// RULE_16 - count pin sampled once per machine cycle; high then low counts one
// RULE_17 - 13-bit mode uses all high byte and low 5 bits of low byte
// RULE_18 - 16-bit rollover from ffff to 0000 sets the overflow flag
// RULE_19 - mode register resets to zero: gate off, internal source, 13-bit
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

`define DTC_RUN_ADDR 8'h88
`define DTC_MODE_CFG_ADDR 8'h89
`define DTC_T0_LOW_ADDR 8'h8a
`define DTC_T1_LOW_ADDR 8'h8b
`define DTC_T0_HIGH_ADDR 8'h8c
`define DTC_T1_HIGH_ADDR 8'h8d
`define DTC_PRESCALE_ADDR 8'h8e
`define DTC_IRQ_STAT_ADDR 8'h90
`define DTC_IRQ_MASK_ADDR 8'h91

`define DTC_MODE_CFG_RST 8'h00
`define DTC_PRESCALE_RST 8'h00
`define DTC_PRESCALE_MASK 8'h18
`define DTC_FAST_BIT_BASE 3
`define DTC_MODE_STRIDE 4
`define DTC_SRC_OFS 2
`define DTC_GATE_OFS 3
`define DTC_RUN_MASK 8'h03
`define DTC_IRQ_MASK_BITS 8'h07
`define DTC_ST_SPLIT_OVF 2

`define DTC_DIV_SLOW 4'hc
`define DTC_DIV_FAST 4'h4

`endif

// >>> hdl/dtc_pkg.sv
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_13BIT = 2'b00,
    DTC_MODE_16BIT = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_e;
endpackage

// >>> verification/dtc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_checker (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_irq_pin0,
  input wire logic i_ext_irq_pin1,
  input wire logic i_timer0_count_pin,
  input wire logic i_timer1_count_pin,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq
);
  logic [7:0] mode, mask, t0l, t1l;
  logic run0, t0_stop, t0_m0, t1_halt;
  // shadows follow bus writes; a count byte is only compared where it cannot move
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {mode, mask, t0l, t1l, run0, t0_stop, t0_m0, t1_halt} <= '0;
    end else if (i_wr) begin
      case (i_addr)
        8'h88: begin
          run0 <= i_wdata[0];
          t0_stop <= t0_stop & !i_wdata[0];
        end
        8'h89: begin
          mode <= i_wdata;
          t0_m0 <= t0_m0 & (i_wdata[1:0] == 2'b00);
          t1_halt <= t1_halt & (i_wdata[5:4] == 2'b11);
        end
        8'h8a: begin
          t0l <= i_wdata;
          t0_stop <= !run0;
          t0_m0 <= mode[1:0] == 2'b00;
        end
        8'h8b: begin
          t1l <= i_wdata;
          t1_halt <= mode[5:4] == 2'b11;
        end
        8'h91: mask <= i_wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd(logic [7:0] a);
    i_rd && i_addr == a;
  endsequence
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (i_rd && (i_addr < 8'h88 || i_addr == 8'h8f || i_addr > 8'h91) |=> !o_rdata)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (s_rd(8'h89) |=> o_rdata == mode) else $error("mode readback");
  a_prescale_rsvd: assert property (s_rd(8'h8e) |=> (o_rdata & 8'he7) == 8'h00) else $error("reserved bits");
  a_irq_masked: assert property (!$past(mask[2:0], 2) && !$past(mask[2:0]) |-> !o_irq)
    else $error("masked irq raised");
  a_t0_stopped: assert property (s_rd(8'h8a) && t0_stop |=> o_rdata == t0l) else $error("t0 moved");
  a_t1_halted: assert property (s_rd(8'h8b) && t1_halt |=> o_rdata == t1l) else $error("t1 moved");
  a_low_top_kept: assert property (s_rd(8'h8a) && t0_m0 |=> o_rdata[7:5] == t0l[7:5])
    else $error("low top bits changed");
endmodule
bind dtc_top dtc_checker u_chk (.*);
`default_nettype wire

// >>> verification/dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic i_clk,
  output logic o_cnt0,
  output logic o_cnt1
);
  // pins idle high as on a pulled-up line
  initial {o_cnt0, o_cnt1} = 2'b11;
  // 36 clocks per level outlasts two slow machine cycles plus synchroniser
  task automatic pulse(input int sel, input int num);
    repeat (2 * num) begin
      repeat (36) @(posedge i_clk);
      if (sel == 0) o_cnt0 <= !o_cnt0;
      else o_cnt1 <= !o_cnt1;
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_core_clk, i_resetn, i_wr, i_rd, i_ext_irq_pin0, i_ext_irq_pin1, rd_d, o_irq, cnt0, cnt1;
  logic [7:0] i_addr, i_wdata, o_rdata, v;
  logic [15:0] q[$];
  logic [15:0] x;
  int num_errors = 0, num_checks = 0, seed = 32'h434b, n, dv;
  dtc_top dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_ext_irq_pin0(i_ext_irq_pin0), .i_ext_irq_pin1(i_ext_irq_pin1),
    .i_timer0_count_pin(cnt0), .i_timer1_count_pin(cnt1), .o_rdata(o_rdata), .o_irq(o_irq));
  dtc_pin_model u_pins (.i_clk(i_core_clk), .o_cnt0(cnt0), .o_cnt1(cnt1));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_core_clk);
    {i_addr, i_rd} <= {a, 1'b1};
    q.push_back({m, e});
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) rd_d <= i_rd;
  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(negedge i_core_clk) begin
    if (rd_d === 1'b1) begin
      x = q.pop_front();
      check(o_rdata & x[15:8], x[7:0]);
    end
  end
  initial begin
    {i_resetn, i_wr, i_rd, rd_d, i_ext_irq_pin0, i_ext_irq_pin1, i_addr, i_wdata} = '0;
    repeat (16) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rd(8'h89, 8'hff, 8'h00);
    rd(8'h8e, 8'hff, 8'h00);
    wr(8'h8e, 8'hff);
    rd(8'h8e, 8'hff, 8'h18);
    rd(8'h8f, 8'hff, 8'h00);
    {i_ext_irq_pin0, i_ext_irq_pin1} <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      automatic int t = i % 2;
      automatic int f = i / 2;
      dv = f ? 4 : 12;
      wr(8'h88, 8'h00);
      wr(8'h89, f ? 8'h99 : 8'h11);
      wr(8'h8e, 8'(f << (3 + t)));
      wr(8'(8'h8a + t), 8'hf6);
      wr(8'(8'h8c + t), 8'hff);
      wr(8'h91, 8'h01 << t);
      wr(8'h90, 8'h07);
      wr(8'h88, 8'h01 << t);
      for (n = 1; n < 300 && o_irq !== 1'b1; n++) @(negedge i_core_clk);
      check(8'(n >= 9 * dv && n <= 10 * dv + 4), 8'h01);
      if (n == 300) report_and_stop();
      rd(8'h90, 8'hff, 8'h01 << t);
      rd(8'(8'h8c + t), 8'hff, 8'h00);
    end
    {i_ext_irq_pin0, i_ext_irq_pin1} <= 2'b00;
    v = 8'($random(seed));
    wr(8'h89, 8'h99);
    wr(8'h8a, v);
    wr(8'h8b, ~v);
    wr(8'h88, 8'h03);
    repeat (100) @(posedge i_core_clk);
    rd(8'h8a, 8'hff, v);
    rd(8'h8b, 8'hff, ~v);
    wr(8'h89, 8'h55);
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h00);
    u_pins.pulse(0, 3);
    u_pins.pulse(1, 2);
    rd(8'h8a, 8'hff, 8'h03);
    rd(8'h8b, 8'hff, 8'h02);
    for (int i = 0; i < 4; i++) begin
      automatic int t = i % 2;
      automatic logic r = i / 2;
      wr(8'h88, 8'h00);
      wr(8'h89, 8'((r ? 2 : 0) << (4 * t)));
      wr(8'(8'h8a + t), 8'hfe);
      wr(8'(8'h8c + t), r ? 8'hf0 : 8'h00);
      wr(8'h8e, 8'h00);
      wr(8'h88, 8'h01 << t);
      repeat (40) @(posedge i_core_clk);
      wr(8'h88, 8'h00);
      rd(8'(8'h8c + t), 8'hff, r ? 8'hf0 : 8'h01);
      rd(8'(8'h8a + t), r ? 8'hf0 : 8'he0, r ? 8'hf0 : 8'he0);
    end
    v = 8'($random(seed));
    wr(8'h89, 8'h33);
    wr(8'h8a, v);
    wr(8'h8b, ~v);
    wr(8'h8c, 8'hff);
    wr(8'h91, 8'h04);
    wr(8'h90, 8'h07);
    wr(8'h88, 8'h02);
    repeat (40) @(posedge i_core_clk);
    rd(8'h90, 8'hff, 8'h04);
    rd(8'h8a, 8'hff, v);
    rd(8'h8b, 8'hff, ~v);
    report_and_stop();
  end
endmodule
`default_nettype wire
